// [bench/spm_comp_model.sv]
`timescale 1ns/100ps
// ----------------------------------------
// behavioural comparator on the io supply rail
// ----------------------------------------
module spm_comp_model (
  // control from the block
  input wire logic monitor_enable,
  input wire logic trip_select,
  // rail level in millivolts, set by the bench
  input wire logic [31:0] io_supply_mv,
  // comparator output, unsynchronised
  output logic supply_compare_raw
);
  // trip point in mV follows the select bit
  int trip_mv;
  assign trip_mv = trip_select ? 3070 : 2790;
  // powered down reads as above trip, so a disabled monitor never flags
  assign supply_compare_raw = !monitor_enable || (io_supply_mv > trip_mv);
endmodule

// [bench/testbench.sv]
`timescale 1ns/100ps
`include "spm_map.svh"
module testbench;
  import spm_pkg::*;
  // ----------------------------------------
  // design signals
  // ----------------------------------------
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, raw, mon_en, trip_sel, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  spm_resp_t bresp, rresp;
  // rail level in mV
  int mv;
  // counters and reference model state
  int fail_count, samples_checked, en, trip, flag, armed, nen, fen, rec, cprev;
  spm_top u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .supply_compare_raw(raw), .monitor_enable(mon_en), .trip_select(trip_sel), .irq(irq));
  spm_comp_model u_cmp (.monitor_enable(mon_en), .trip_select(trip_sel), .io_supply_mv(mv),
    .supply_compare_raw(raw));
  // 10 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // model comparator, 1 when disabled
  function automatic int cmp_f();
    return (!en || mv > (trip ? 3070 : 2790)) ? 1 : 0;
  endfunction
  // verdict, the single exit of the run
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // compare one value
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // bounded wait for a signal seen high at a rising edge
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (s !== 1'b1 && n < 64);
    if (s !== 1'b1)
    begin
      fail_count++;
      end_of_test();
    end
  endtask
  // let the sync chain settle, then advance the model flag
  task automatic settle();
    repeat (6) @(posedge aclk);
    if (!cmp_f() && armed)
    begin
      flag = 1;
      armed = 0;
    end
    if (cmp_f())
      armed = 1;
    // recovery event is sticky until cleared
    if (cmp_f() && !cprev)
      rec = 1;
    cprev = cmp_f();
    check({31'h0, irq}, (flag && (nen || fen)) ? 1 : 0);
    check({30'h0, trip_sel, mon_en}, {trip[0], en[0]});
  endtask
  // ----------------------------------------
  // axi4-lite master
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input spm_resp_t er);
    int c;
    c = cmp_f();
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    wait_hi(awready);
    check({31'h0, wready}, 32'h1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    wait_hi(bvalid);
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, er});
    // clear only lands while the comparator reads high
    case (a)
      `SPM_OFS_CTRL:
      begin
        en = d[1];
        trip = d[2];
        if (d[0] && c)
          flag = 0;
      end
      `SPM_OFS_CLR:
      begin
        if (d[0] && c)
          flag = 0;
        if (d[1])
          rec = 0;
      end
      `SPM_OFS_NEN: nen = d[0];
      `SPM_OFS_FEN: fen = d[0];
      default: ;
    endcase
    settle();
  endtask
  task automatic rd(input logic [7:0] a);
    logic [31:0] e;
    spm_resp_t r;
    e = 32'h0;
    r = `SPM_RESP_OK;
    // status holds the flag and the sticky recovery bit
    case (a)
      `SPM_OFS_CTRL: e = (cmp_f() << 3) | (trip << 2) | (en << 1) | flag;
      `SPM_OFS_STAT: e = (rec << 1) | flag;
      `SPM_OFS_CLR: e = 32'h0;
      `SPM_OFS_NEN: e = nen;
      `SPM_OFS_FEN: e = fen;
      default: r = `SPM_RESP_ERR;
    endcase
    // rready stays high after the answer so back-to-back reads drive it once per step
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    wait_hi(arready);
    arvalid <= 1'b0;
    wait_hi(rvalid);
    check(rdata, e);
    check({30'h0, rresp}, {30'h0, r});
  endtask
  // move the rail, settle, read control back
  task automatic step(input int v);
    mv <= v;
    settle();
    rd(`SPM_OFS_CTRL);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    mv = 3300;
    en = 0;
    trip = 0;
    flag = 0;
    armed = 1;
    nen = 0;
    fen = 0;
    rec = 0;
    cprev = 1;
    fail_count = 0;
    samples_checked = 0;
    void'($urandom(32'h43c6));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, unmapped read, read-only write
    for (int i = 0; i < 6; i++)
      rd(8'(i * 4));
    wr(`SPM_OFS_STAT, 32'h1, `SPM_RESP_ERR);
    // reserved ones must not stick
    wr(`SPM_OFS_CTRL, 32'hfff2, `SPM_RESP_OK);
    rd(`SPM_OFS_CTRL);
    // normal enable on pass 0, fast enable on pass 1
    for (int t = 0; t < 2; t++)
    begin
      wr(`SPM_OFS_CTRL, 32'h2 | (t << 2), `SPM_RESP_OK);
      step(2800 + $urandom % 250);
      step(2000 + $urandom % 700);
      wr(t ? `SPM_OFS_FEN : `SPM_OFS_NEN, 32'h1, `SPM_RESP_OK);
      wr(`SPM_OFS_CTRL, 32'h3 | (t << 2), `SPM_RESP_OK);
      rd(`SPM_OFS_STAT);
      // software waits for the rail before clearing
      step(3100 + $urandom % 500);
      wr(`SPM_OFS_CTRL, 32'h2 | (t << 2), `SPM_RESP_OK);
      wr(t ? `SPM_OFS_CLR : `SPM_OFS_CTRL, 32'h3, `SPM_RESP_OK);
      rd(`SPM_OFS_CLR);
      rd(`SPM_OFS_CTRL);
      wr(t ? `SPM_OFS_FEN : `SPM_OFS_NEN, 32'h0, `SPM_RESP_OK);
    end
    // disabling while low reads as high, then the flag clears
    wr(`SPM_OFS_NEN, 32'h1, `SPM_RESP_OK);
    step(2100);
    wr(`SPM_OFS_CTRL, 32'h0, `SPM_RESP_OK);
    rd(`SPM_OFS_CTRL);
    wr(`SPM_OFS_CTRL, 32'h1, `SPM_RESP_OK);
    rd(`SPM_OFS_STAT);
    end_of_test();
  end
endmodule

// [common/spm_map.svh]
`ifndef SPM_MAP_SVH
`define SPM_MAP_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SPM_ADDR_W 8
`define SPM_OFS_CTRL 8'h00
`define SPM_OFS_STAT 8'h04
`define SPM_OFS_CLR 8'h08
`define SPM_OFS_NEN 8'h0c
`define SPM_OFS_FEN 8'h10
// ----------------------------------------
// control register fields
// ----------------------------------------
`define SPM_BIT_FLAG 0
`define SPM_BIT_EN 1
`define SPM_BIT_TRIP 2
`define SPM_BIT_CMP 3
`define SPM_CTRL_W 16
// ----------------------------------------
// interrupt status fields
// ----------------------------------------
`define SPM_ST_LOW 0
`define SPM_ST_REC 1
`define SPM_ST_W 2
// ----------------------------------------
// reset values and responses
// ----------------------------------------
`define SPM_RST_EN 1'h0
`define SPM_RST_TRIP 1'h0
`define SPM_RST_EVT 2'h0
`define SPM_RST_CMP 1'h1
`define SPM_RESP_OK 2'h0
`define SPM_RESP_ERR 2'h2
`define SPM_SYNC_STAGES 2
`endif

// [common/spm_pkg.sv]
`include "spm_map.svh"
package spm_pkg;
  // register selected by a bus address
  typedef enum logic [2:0] {
    SPM_SEL_CTRL,
    SPM_SEL_STAT,
    SPM_SEL_CLR,
    SPM_SEL_NEN,
    SPM_SEL_FEN,
    SPM_SEL_NONE
  } spm_sel_t;
  // one bit per interrupt event
  typedef logic [`SPM_ST_W-1:0] spm_evt_t;
  // bus response code
  typedef logic [1:0] spm_resp_t;
endpackage

// [hdl/spm_sync.sv]
`timescale 1ns/100ps
`include "spm_map.svh"
// ----------------------------------------
// level synchroniser, resets to a chosen level
// ----------------------------------------
module spm_sync #(
  parameter int STAGES = `SPM_SYNC_STAGES,
  parameter logic RST_VAL = `SPM_RST_CMP
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // async level in, synced level out
  input wire logic din,
  output logic dout
);
  logic [STAGES-1:0] stage_q; // shift chain, only the last stage is read

  // chain shifts toward the top; first stage feeds only the next
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stage_q <= {STAGES{RST_VAL}};
    else
      stage_q <= {stage_q[STAGES-2:0], din};
  end

  assign dout = stage_q[STAGES-1];
endmodule

// [hdl/spm_top.sv]
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "spm_map.svh"
module spm_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [`SPM_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output spm_pkg::spm_resp_t bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [`SPM_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output spm_pkg::spm_resp_t rresp,
  // analog comparator side
  input wire logic supply_compare_raw,
  output logic monitor_enable,
  output logic trip_select,
  // interrupt to the core
  output logic irq
);
  import spm_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic awready_q; // write handshake strobe
  logic wready_q; // paired with awready_q
  logic bvalid_q; // write answer pending
  spm_resp_t bresp_q; // write answer code
  logic arready_q; // read handshake strobe
  logic rvalid_q; // read answer pending
  logic [31:0] rdata_q; // read answer data
  spm_resp_t rresp_q; // read answer code
  logic enable_q; // monitor_enable_bit
  logic trip_q; // trip_select
  logic flag_q; // low_supply_irq_flag
  logic arm_q; // may set flag again
  spm_evt_t stat_q; // sticky events
  spm_evt_t nen_q; // normal_irq_enable_reg
  spm_evt_t fen_q; // fast_irq_enable_reg
  logic irq_q; // registered interrupt level
  logic cmp_sync; // synchronised comparator
  logic cmp_prev_q; // for recovery edge
  logic cmp_now; // supply_compare_flag as read
  logic wr_go; // write taken this cycle
  logic rd_go; // read taken this cycle
  spm_sel_t wr_sel; // decoded write target
  spm_sel_t rd_sel; // decoded read target
  logic wr_lo; // low byte lane enabled
  logic flag_set; // flag set this cycle
  logic flag_clr; // flag clear accepted
  logic rec_evt; // supply has recovered
  spm_evt_t st_clr; // status bits to clear

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // shared by read and write paths
  function automatic spm_sel_t spm_decode(input logic [`SPM_ADDR_W-1:0] a);
    spm_sel_t s;
    s = SPM_SEL_NONE;
    case (a)
      `SPM_OFS_CTRL: s = SPM_SEL_CTRL;
      `SPM_OFS_STAT: s = SPM_SEL_STAT;
      `SPM_OFS_CLR: s = SPM_SEL_CLR;
      `SPM_OFS_NEN: s = SPM_SEL_NEN;
      `SPM_OFS_FEN: s = SPM_SEL_FEN;
      default: s = SPM_SEL_NONE;
    endcase
    return s;
  endfunction

  assign wr_sel = spm_decode(awaddr);
  assign rd_sel = spm_decode(araddr);
  assign wr_go = awready_q && awvalid && wvalid;
  assign rd_go = arready_q && arvalid;
  assign wr_lo = wstrb[0];

  // ----------------------------------------
  // comparator path
  // ----------------------------------------
  // two stages; raw level is async to aclk
  spm_sync #(
    .STAGES(`SPM_SYNC_STAGES),
    .RST_VAL(`SPM_RST_CMP)
  ) u_cmp_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(supply_compare_raw),
    .dout(cmp_sync)
  );

  // powered-down comparator output is not trusted, so force high
  assign cmp_now = cmp_sync || !enable_q;

  // previous comparator level for edge detection
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cmp_prev_q <= `SPM_RST_CMP;
    else
      cmp_prev_q <= cmp_now;
  end

  assign rec_evt = cmp_now && !cmp_prev_q;

  // ----------------------------------------
  // low-supply flag
  // ----------------------------------------
  // set only once per episode, re-armed by recovery
  assign flag_set = !cmp_now && arm_q;
  // no delay: clear works as soon as comparator reads high
  assign flag_clr = cmp_now && wr_go && wr_lo &&
    ((wr_sel == SPM_SEL_CTRL && wdata[`SPM_BIT_FLAG]) ||
     (wr_sel == SPM_SEL_CLR && wdata[`SPM_ST_LOW]));

  // flag itself; set wins over a clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flag_q <= 1'h0;
    else if (flag_set)
      flag_q <= 1'h1;
    else if (flag_clr)
      flag_q <= 1'h0;
  end

  // arming: dropped when flag sets, restored when supply is high
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      arm_q <= 1'h1;
    else if (flag_set)
      arm_q <= 1'h0;
    else if (cmp_now)
      arm_q <= 1'h1;
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  // enable and trip drive the analog cell directly
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      enable_q <= `SPM_RST_EN;
      trip_q <= `SPM_RST_TRIP;
    end
    else if (wr_go && wr_lo && wr_sel == SPM_SEL_CTRL)
    begin
      enable_q <= wdata[`SPM_BIT_EN];
      trip_q <= wdata[`SPM_BIT_TRIP];
    end
  end

  // ----------------------------------------
  // interrupt status, clear and enables
  // ----------------------------------------
  // recovery bit clears by write-one; low bit follows flag
  assign st_clr = (wr_go && wr_lo && wr_sel == SPM_SEL_CLR) ?
    wdata[`SPM_ST_W-1:0] : `SPM_RST_EVT;

  // sticky recovery event, set wins over clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stat_q <= `SPM_RST_EVT;
    else
    begin
      stat_q[`SPM_ST_LOW] <= flag_set || (flag_q && !flag_clr);
      if (rec_evt)
        stat_q[`SPM_ST_REC] <= 1'h1;
      else if (st_clr[`SPM_ST_REC])
        stat_q[`SPM_ST_REC] <= 1'h0;
    end
  end

  // normal and fast enable registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      nen_q <= `SPM_RST_EVT;
      fen_q <= `SPM_RST_EVT;
    end
    else if (wr_go && wr_lo)
    begin
      if (wr_sel == SPM_SEL_NEN)
        nen_q <= wdata[`SPM_ST_W-1:0];
      if (wr_sel == SPM_SEL_FEN)
        fen_q <= wdata[`SPM_ST_W-1:0];
    end
  end

  // level output; either enable register passes a source
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_q <= 1'h0;
    else
      irq_q <= |(stat_q & (nen_q | fen_q));
  end

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  // waits for address and data together, then one answer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'h0;
      wready_q <= 1'h0;
      bvalid_q <= 1'h0;
      bresp_q <= `SPM_RESP_OK;
    end
    else
    begin
      awready_q <= awvalid && wvalid && !awready_q && !bvalid_q;
      wready_q <= awvalid && wvalid && !awready_q && !bvalid_q;
      if (wr_go)
      begin
        bvalid_q <= 1'h1;
        // status is read-only, unmapped gets an error
        if (wr_sel == SPM_SEL_NONE || wr_sel == SPM_SEL_STAT)
          bresp_q <= `SPM_RESP_ERR;
        else
          bresp_q <= `SPM_RESP_OK;
      end
      else if (bready)
        bvalid_q <= 1'h0;
    end
  end

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  // reserved and upper bits always read zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'h0;
      rvalid_q <= 1'h0;
      rdata_q <= 32'h0;
      rresp_q <= `SPM_RESP_OK;
    end
    else
    begin
      arready_q <= arvalid && !arready_q && !rvalid_q;
      if (rd_go)
      begin
        rvalid_q <= 1'h1;
        rdata_q <= 32'h0;
        rresp_q <= `SPM_RESP_OK;
        case (rd_sel)
          SPM_SEL_CTRL:
          begin
            rdata_q[`SPM_BIT_FLAG] <= flag_q;
            rdata_q[`SPM_BIT_EN] <= enable_q;
            rdata_q[`SPM_BIT_TRIP] <= trip_q;
            rdata_q[`SPM_BIT_CMP] <= cmp_now;
          end
          SPM_SEL_STAT: rdata_q[`SPM_ST_W-1:0] <= stat_q;
          SPM_SEL_NEN: rdata_q[`SPM_ST_W-1:0] <= nen_q;
          SPM_SEL_FEN: rdata_q[`SPM_ST_W-1:0] <= fen_q;
          SPM_SEL_CLR: rresp_q <= `SPM_RESP_OK; // write-only, reads zero
          default: rresp_q <= `SPM_RESP_ERR;
        endcase
      end
      else if (rready)
        rvalid_q <= 1'h0;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign monitor_enable = enable_q;
  assign trip_select = trip_q;
  assign irq = irq_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic [1:0] rst_age_q; // cycles since reset, saturating
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rst_age_q <= 2'h0;
    else if (rst_age_q != 2'h3)
      rst_age_q <= rst_age_q + 2'h1;
  end

  enable_pin_a: assert property (
    wr_go && wr_lo && wr_sel == SPM_SEL_CTRL |=> monitor_enable == $past(wdata[`SPM_BIT_EN])
  ) else $error("monitor enable did not follow write");

  trip_pin_a: assert property (
    wr_go && wr_lo && wr_sel == SPM_SEL_CTRL |=> trip_select == $past(wdata[`SPM_BIT_TRIP])
  ) else $error("trip select did not follow write");

  cmp_off_a: assert property (
    rd_go && rd_sel == SPM_SEL_CTRL && !enable_q |=> rdata[`SPM_BIT_CMP]
  ) else $error("comparator bit low while powered down");

  flag_set_a: assert property (
    !cmp_now && arm_q |=> flag_q && !arm_q
  ) else $error("low supply did not set flag");

  zero_write_a: assert property (
    flag_q && !(wr_go && wdata[`SPM_BIT_FLAG]) && !(wr_go && wdata[`SPM_ST_LOW]) |=> flag_q
  ) else $error("flag dropped without write one");

  quick_clear_a: assert property (
    flag_q && cmp_now && wr_go && wr_lo && wr_sel == SPM_SEL_CTRL && wdata[`SPM_BIT_FLAG] |=> !flag_q
  ) else $error("clear refused after recovery");

  irq_gate_a: assert property (
    !(|(stat_q & (nen_q | fen_q))) |=> !irq
  ) else $error("interrupt raised without enable");

  one_shot_a: assert property (
    !arm_q && !cmp_now |=> !arm_q
  ) else $error("flag rearmed while supply low");

  rsv_zero_a: assert property (
    rvalid |-> rdata[31:`SPM_BIT_CMP+1] == 28'h0
  ) else $error("reserved bits read nonzero");

  sync_lat_a: assert property (
    rst_age_q == 2'h3 |-> cmp_sync == $past(supply_compare_raw, 2)
  ) else $error("comparator sync latency wrong");
endmodule
